// ==== ufds_pkg.sv ====
/*
 Constants, addresses and types shared by the UART data path and FIFO status block.
 Assumes one 50 MHz clock and an AHB-Lite bus with 32-bit data.
*/
package ufds_pkg;

   // Storage geometry
   localparam int DATA_W     = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W      = 4;
   localparam int CNT_W      = 5;

   // Register byte addresses
   localparam logic [31:0] ALIAS_FIRST_ADDR         = 32'h5000_1130;
   localparam logic [31:0] RX_TX_DATA_ALIAS_15_ADDR = 32'h5000_116C;
   localparam logic [31:0] FIFO_STATUS_ADDR         = 32'h5000_117C;
   localparam logic [31:0] CTRL_ADDR                = 32'h5000_1200;
   localparam logic [31:0] LINE_STATUS_ADDR         = 32'h5000_1204;
   localparam logic [31:0] INT_STATUS_ADDR          = 32'h5000_1208;
   localparam logic [31:0] INT_MASK_ADDR            = 32'h5000_120C;
   localparam logic [1:0]  WORD_ALIGNED             = 2'h0;

   // Field positions of the FIFO status word
   localparam int ST_RFF  = 4;
   localparam int ST_RFNE = 3;
   localparam int ST_TFE  = 2;
   localparam int ST_TFNF = 1;

   // Control word fields and reset value
   localparam int          CTRL_FIFO_EN = 0;
   localparam int          CTRL_IR_MODE = 1;
   localparam logic [1:0]  CTRL_RST     = 2'h0;

   // Line status word fields
   localparam int LS_DATA_READY = 0;
   localparam int LS_OVERRUN    = 1;
   localparam int LS_HOLD_EMPTY = 5;

   // Interrupt status and mask layout
   localparam int         INT_W       = 3;
   localparam int         INT_RX      = 0;
   localparam int         INT_OVERRUN = 1;
   localparam int         INT_TX_IDLE = 2;
   localparam logic [2:0] INT_RST     = 3'h0;

   // Serial timing in clock cycles
   localparam logic [3:0] BIT_LAST   = 4'hF;
   localparam logic [3:0] HALF_LAST  = 4'h7;
   localparam logic [3:0] IR_PULSE   = 4'h3;
   localparam logic [2:0] DATA_LAST  = 3'h7;

   // Serial engine states
   typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} ufds_ser_type;

endpackage : ufds_pkg

// ==== ufds_fifo.sv ====
/*
 Sixteen-entry byte FIFO with clear, used for both receive and transmit.
 Assumes a synchronous active-low reset; pops while empty and pushes while full, unless clearing, are ignored.
*/
module ufds_fifo (
   // Clock and reset
   input  wire logic                            clk,
   input  wire logic                            rst_n,
   // Control
   input  wire logic                            clr,
   input  wire logic                            push,
   input  wire logic                            pop,
   input  wire logic [ufds_pkg::DATA_W-1:0]     din,
   // State
   output logic      [ufds_pkg::DATA_W-1:0]     dout,
   output logic      [ufds_pkg::CNT_W-1:0]      count,
   output logic                                 full,
   output logic                                 empty
);

   logic [ufds_pkg::PTR_W-1:0]  rd_q;
   logic [ufds_pkg::PTR_W-1:0]  wr_q;
   logic [ufds_pkg::PTR_W-1:0]  wr_idx;
   logic [ufds_pkg::CNT_W-1:0]  cnt_q;
   logic [ufds_pkg::DATA_W-1:0] mem_q [ufds_pkg::FIFO_DEPTH];
   logic                        do_push;
   logic                        do_pop;

   // Clear empties first, so a push in the same cycle lands alone
   assign do_push = push && (clr || !full);
   assign do_pop  = pop && !empty && !clr;
   assign wr_idx  = clr ? '0 : wr_q;

   genvar i;
   for (i = 0; i < ufds_pkg::FIFO_DEPTH; i++) begin : g_entry
      always_ff @(posedge clk) begin
         if (do_push && wr_idx == ufds_pkg::PTR_W'(i)) begin
            mem_q[i] <= din;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_q  <= '0;
         wr_q  <= '0;
         cnt_q <= '0;
      end else if (clr) begin
         rd_q  <= '0;
         wr_q  <= do_push ? 4'h1 : 4'h0;
         cnt_q <= do_push ? 5'h01 : 5'h00;
      end else begin
         if (do_push) begin
            wr_q <= wr_q + 4'h1;
         end
         if (do_pop) begin
            rd_q <= rd_q + 4'h1;
         end
         case ({do_push, do_pop})
            2'h2:    cnt_q <= cnt_q + 5'h01;
            2'h1:    cnt_q <= cnt_q - 5'h01;
            default: cnt_q <= cnt_q;
         endcase
      end
   end

   assign dout  = mem_q[rd_q];
   assign count = cnt_q;
   assign full  = cnt_q == ufds_pkg::CNT_W'(ufds_pkg::FIFO_DEPTH);
   assign empty = cnt_q == '0;

endmodule : ufds_fifo

// ==== ufds_top.sv ====
/*
 UART data path slice: aliased data window, receive and transmit FIFOs, FIFO status word,
 a small 8N1 serial engine with an infrared option, and an interrupt.
 Assumes an AHB-Lite master with single word transfers and asynchronous serial inputs.
*/
// Register access over AHB-Lite was left to the implementer.
// Function
// - Sixteen word-spaced addresses all reach the same data byte in bits 7 to 0.
// - Reading the data byte gives the character received on the serial or infrared input.
// - Without FIFOs a new character overwrites an unread one and flags overrun.
// - With FIFOs a read of the data byte returns and removes the receive FIFO head.
// - A character arriving at a full receive FIFO is dropped, the FIFO kept, overrun flagged.
// - A written character goes out on the serial output, or the active-low infrared output.
// - Without FIFOs one write clears holding-empty and further writes overwrite the pending byte.
// - With FIFOs writes are taken up to sixteen deep and dropped while the FIFO is full.
// - Status bit 4 is 1 exactly while the receive FIFO is full, reset 0.
// - Status bit 3 is 1 while the receive FIFO holds any entry, reset 0.
// - Status bit 2 is 1 while the transmit FIFO is empty, reset 1.
// - Status bit 1 is 1 while the transmit FIFO is not full, reset 1.
module ufds_top (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RESET_N,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Serial and infrared lines
   input  wire logic        SER_IN,
   input  wire logic        IR_IN,
   output logic             SER_OUT,
   output logic             IR_OUT_N,
   // Interrupt
   output logic             IRQ
);

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);

   logic                               pend_q;
   logic                               pend_wr_q;
   logic [31:0]                        pend_addr_q;
   logic                               hready_q;
   logic [31:0]                        hrdata_q;
   logic                               take;
   logic                               wr_acc;
   logic                               rd_acc;
   logic                               is_alias;
   logic [31:0]                        rd_val;
   logic [1:0]                         ctrl_q;
   logic [ufds_pkg::INT_W-1:0]         int_stat_q;
   logic [ufds_pkg::INT_W-1:0]         int_mask_q;
   logic [ufds_pkg::INT_W-1:0]         int_set;
   logic [ufds_pkg::INT_W-1:0]         int_w1c;
   logic                               irq_q;
   logic                               oe_q;
   logic                               he_prev_q;
   logic                               fifo_en;
   logic                               ir_mode;
   logic                               en_chg;
   logic                               ls_rd;
   // Receive side
   logic                               ser_s1_q;
   logic                               ser_s2_q;
   logic                               ir_s1_q;
   logic                               ir_s2_q;
   logic                               ir_seen_q;
   ufds_pkg::ufds_ser_type             rx_st_q;
   logic [3:0]                         rx_cnt_q;
   logic [2:0]                         rx_idx_q;
   logic [ufds_pkg::DATA_W-1:0]        rx_sh_q;
   logic                               rx_got_q;
   logic                               line_bit;
   logic                               start_det;
   logic                               sample_now;
   logic                               rx_clr;
   logic                               rx_pop;
   logic                               ovr_ev;
   logic [ufds_pkg::DATA_W-1:0]        rx_dout;
   logic [ufds_pkg::CNT_W-1:0]         rx_cnt;
   logic                               rx_full;
   logic                               rx_empty;
   // Transmit side
   ufds_pkg::ufds_ser_type             tx_st_q;
   logic [3:0]                         tx_cnt_q;
   logic [2:0]                         tx_idx_q;
   logic [ufds_pkg::DATA_W-1:0]        tx_sh_q;
   logic                               ser_out_q;
   logic                               ir_out_n_q;
   logic                               tx_bit;
   logic                               tx_wr;
   logic                               tx_clr;
   logic                               tx_pop;
   logic [ufds_pkg::DATA_W-1:0]        tx_dout;
   logic [ufds_pkg::CNT_W-1:0]         tx_cnt;
   logic                               tx_full;
   logic                               tx_empty;

   assign fifo_en = ctrl_q[ufds_pkg::CTRL_FIFO_EN];
   assign ir_mode = ctrl_q[ufds_pkg::CTRL_IR_MODE];

   // Bus slave: one wait state on every transfer, so read data comes from a flop
   assign take   = HSEL && HTRANS[1] && HREADY;
   assign wr_acc = pend_q && pend_wr_q;
   assign rd_acc = pend_q && !pend_wr_q;
   assign is_alias = pend_addr_q >= ufds_pkg::ALIAS_FIRST_ADDR &&
                     pend_addr_q <= ufds_pkg::RX_TX_DATA_ALIAS_15_ADDR &&
                     pend_addr_q[1:0] == ufds_pkg::WORD_ALIGNED;

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         pend_q      <= 1'b0;
         pend_wr_q   <= 1'b0;
         pend_addr_q <= '0;
         hready_q    <= 1'b1;
      end else begin
         pend_q   <= take;
         hready_q <= !take;
         if (take) begin
            pend_wr_q   <= HWRITE;
            pend_addr_q <= HADDR;
         end
      end
   end

   always_comb begin
      rd_val = '0;
      if (is_alias) begin
         rd_val[ufds_pkg::DATA_W-1:0] = rx_dout;
      end else begin
         case (pend_addr_q)
            ufds_pkg::FIFO_STATUS_ADDR: begin
               rd_val[ufds_pkg::ST_RFF]  = rx_full;
               rd_val[ufds_pkg::ST_RFNE] = !rx_empty;
               rd_val[ufds_pkg::ST_TFE]  = tx_empty;
               rd_val[ufds_pkg::ST_TFNF] = !tx_full;
            end
            ufds_pkg::CTRL_ADDR:        rd_val[1:0] = ctrl_q;
            ufds_pkg::LINE_STATUS_ADDR: begin
               rd_val[ufds_pkg::LS_DATA_READY] = !rx_empty;
               rd_val[ufds_pkg::LS_OVERRUN]    = oe_q;
               rd_val[ufds_pkg::LS_HOLD_EMPTY] = tx_empty;
            end
            ufds_pkg::INT_STATUS_ADDR:  rd_val[ufds_pkg::INT_W-1:0] = int_stat_q;
            ufds_pkg::INT_MASK_ADDR:    rd_val[ufds_pkg::INT_W-1:0] = int_mask_q;
            default:                    rd_val = '0;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         hrdata_q <= '0;
      end else if (rd_acc) begin
         hrdata_q <= rd_val;
      end
   end

   // Control word; toggling FIFO enable flushes both FIFOs
   assign en_chg = wr_acc && pend_addr_q == ufds_pkg::CTRL_ADDR &&
                   HWDATA[ufds_pkg::CTRL_FIFO_EN] != fifo_en;

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         ctrl_q <= ufds_pkg::CTRL_RST;
      end else if (wr_acc && pend_addr_q == ufds_pkg::CTRL_ADDR) begin
         ctrl_q <= HWDATA[1:0];
      end
   end

   // Receive input synchronisers
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         ser_s1_q <= 1'b1;
         ser_s2_q <= 1'b1;
         ir_s1_q  <= 1'b0;
         ir_s2_q  <= 1'b0;
      end else begin
         ser_s1_q <= SER_IN;
         ser_s2_q <= ser_s1_q;
         ir_s1_q  <= IR_IN;
         ir_s2_q  <= ir_s1_q;
      end
   end

   // Infrared zero bits are short pulses, so a pulse is held until the bit's sample point
   assign sample_now = (rx_st_q == ufds_pkg::SER_START && rx_cnt_q == ufds_pkg::HALF_LAST) ||
                       ((rx_st_q == ufds_pkg::SER_DATA || rx_st_q == ufds_pkg::SER_STOP) &&
                        rx_cnt_q == ufds_pkg::BIT_LAST);
   assign line_bit   = ir_mode ? !ir_seen_q : ser_s2_q;
   assign start_det  = ir_mode ? ir_s2_q : !ser_s2_q;

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         ir_seen_q <= 1'b0;
      end else if (ir_s2_q) begin
         ir_seen_q <= 1'b1;
      end else if (sample_now) begin
         ir_seen_q <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         rx_st_q  <= ufds_pkg::SER_IDLE;
         rx_cnt_q <= '0;
         rx_idx_q <= '0;
         rx_sh_q  <= '0;
         rx_got_q <= 1'b0;
      end else begin
         rx_got_q <= 1'b0;
         rx_cnt_q <= rx_cnt_q + 4'h1;
         case (rx_st_q)
            ufds_pkg::SER_IDLE: begin
               rx_cnt_q <= '0;
               if (start_det) begin
                  rx_st_q <= ufds_pkg::SER_START;
               end
            end
            ufds_pkg::SER_START: begin
               if (sample_now) begin
                  rx_cnt_q <= '0;
                  rx_idx_q <= '0;
                  rx_st_q  <= line_bit ? ufds_pkg::SER_IDLE : ufds_pkg::SER_DATA;
               end
            end
            ufds_pkg::SER_DATA: begin
               if (sample_now) begin
                  rx_sh_q  <= {line_bit, rx_sh_q[ufds_pkg::DATA_W-1:1]};
                  rx_idx_q <= rx_idx_q + 3'h1;
                  if (rx_idx_q == ufds_pkg::DATA_LAST) begin
                     rx_st_q <= ufds_pkg::SER_STOP;
                  end
               end
            end
            ufds_pkg::SER_STOP: begin
               if (sample_now) begin
                  rx_got_q <= line_bit;
                  rx_st_q  <= ufds_pkg::SER_IDLE;
               end
            end
            default: rx_st_q <= ufds_pkg::SER_IDLE;
         endcase
      end
   end

   // Receive FIFO; without FIFOs it acts as a one-byte buffer that is overwritten
   assign ovr_ev = rx_got_q && (fifo_en ? rx_full : !rx_empty);
   assign rx_clr = en_chg || (rx_got_q && !fifo_en && !rx_empty);
   assign rx_pop = rd_acc && is_alias;

   ufds_fifo u_rx_fifo (
      .clk   (SYS_CLK),
      .rst_n (RESET_N),
      .clr   (rx_clr),
      .push  (rx_got_q),
      .pop   (rx_pop),
      .din   (rx_sh_q),
      .dout  (rx_dout),
      .count (rx_cnt),
      .full  (rx_full),
      .empty (rx_empty)
   );

   // Overrun is sticky until the line status word is read; a new overrun wins
   assign ls_rd = rd_acc && pend_addr_q == ufds_pkg::LINE_STATUS_ADDR;

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         oe_q <= 1'b0;
      end else if (ovr_ev) begin
         oe_q <= 1'b1;
      end else if (ls_rd) begin
         oe_q <= 1'b0;
      end
   end

   // Transmit FIFO; without FIFOs a pending byte is replaced by the newest write
   assign tx_wr  = wr_acc && is_alias;
   assign tx_clr = en_chg || (tx_wr && !fifo_en && !tx_empty);
   assign tx_pop = tx_st_q == ufds_pkg::SER_IDLE && !tx_empty && !tx_clr;

   ufds_fifo u_tx_fifo (
      .clk   (SYS_CLK),
      .rst_n (RESET_N),
      .clr   (tx_clr),
      .push  (tx_wr),
      .pop   (tx_pop),
      .din   (HWDATA[ufds_pkg::DATA_W-1:0]),
      .dout  (tx_dout),
      .count (tx_cnt),
      .full  (tx_full),
      .empty (tx_empty)
   );

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         tx_st_q  <= ufds_pkg::SER_IDLE;
         tx_cnt_q <= '0;
         tx_idx_q <= '0;
         tx_sh_q  <= '0;
      end else begin
         tx_cnt_q <= tx_cnt_q + 4'h1;
         case (tx_st_q)
            ufds_pkg::SER_IDLE: begin
               tx_cnt_q <= '0;
               tx_idx_q <= '0;
               if (tx_pop) begin
                  tx_sh_q <= tx_dout;
                  tx_st_q <= ufds_pkg::SER_START;
               end
            end
            ufds_pkg::SER_START: begin
               if (tx_cnt_q == ufds_pkg::BIT_LAST) begin
                  tx_st_q <= ufds_pkg::SER_DATA;
               end
            end
            ufds_pkg::SER_DATA: begin
               if (tx_cnt_q == ufds_pkg::BIT_LAST) begin
                  tx_sh_q  <= {1'b0, tx_sh_q[ufds_pkg::DATA_W-1:1]};
                  tx_idx_q <= tx_idx_q + 3'h1;
                  if (tx_idx_q == ufds_pkg::DATA_LAST) begin
                     tx_st_q <= ufds_pkg::SER_STOP;
                  end
               end
            end
            ufds_pkg::SER_STOP: begin
               if (tx_cnt_q == ufds_pkg::BIT_LAST) begin
                  tx_st_q <= ufds_pkg::SER_IDLE;
               end
            end
            default: tx_st_q <= ufds_pkg::SER_IDLE;
         endcase
      end
   end

   assign tx_bit = tx_st_q == ufds_pkg::SER_START ? 1'b0 :
                   tx_st_q == ufds_pkg::SER_DATA  ? tx_sh_q[0] : 1'b1;

   // Infrared output pulses low at the start of each zero bit
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         ser_out_q  <= 1'b1;
         ir_out_n_q <= 1'b1;
      end else begin
         ser_out_q  <= ir_mode ? 1'b1 : tx_bit;
         ir_out_n_q <= !(ir_mode && !tx_bit && tx_cnt_q < ufds_pkg::IR_PULSE);
      end
   end

   // Interrupts: sticky events, write one to clear, set wins over clear
   assign int_set[ufds_pkg::INT_RX]      = rx_got_q;
   assign int_set[ufds_pkg::INT_OVERRUN] = ovr_ev;
   assign int_set[ufds_pkg::INT_TX_IDLE] = tx_empty && !he_prev_q;
   assign int_w1c = (wr_acc && pend_addr_q == ufds_pkg::INT_STATUS_ADDR) ?
                    HWDATA[ufds_pkg::INT_W-1:0] : '0;

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         int_stat_q <= ufds_pkg::INT_RST;
         int_mask_q <= ufds_pkg::INT_RST;
         he_prev_q  <= 1'b1;
         irq_q      <= 1'b0;
      end else begin
         int_stat_q <= (int_stat_q & ~int_w1c) | int_set;
         he_prev_q  <= tx_empty;
         irq_q      <= |(int_stat_q & int_mask_q);
         if (wr_acc && pend_addr_q == ufds_pkg::INT_MASK_ADDR) begin
            int_mask_q <= HWDATA[ufds_pkg::INT_W-1:0];
         end
      end
   end

   assign HRDATA    = hrdata_q;
   assign HREADYOUT = hready_q;
   assign HRESP     = 1'b0;
   assign SER_OUT   = ser_out_q;
   assign IR_OUT_N  = ir_out_n_q;
   assign IRQ       = irq_q;

   a_alias_read_data: assert property (rd_acc && is_alias |=> HRDATA[7:0] == $past(rx_dout))
      else $error("alias read returned wrong byte");
   a_fifo_read_pops: assert property (rd_acc && is_alias && fifo_en && !rx_empty && !rx_got_q
                                      |=> rx_cnt == $past(rx_cnt) - 5'h01)
      else $error("fifo read did not consume head");
   a_nofifo_overwrite: assert property (rx_got_q && !fifo_en && !rx_empty
                                        |=> oe_q && rx_cnt == 5'h01 && rx_dout == $past(rx_sh_q))
      else $error("unread byte not overwritten with overrun");
   a_full_rx_drop: assert property (rx_got_q && fifo_en && rx_full && !rx_pop && !en_chg
                                    |=> oe_q && rx_full && rx_dout == $past(rx_dout))
      else $error("full receive fifo changed on arrival");
   a_tx_overwrite: assert property (tx_wr && !fifo_en && !tx_empty && !en_chg
                                    |=> tx_cnt == 5'h01 && tx_dout == $past(HWDATA[7:0]))
      else $error("pending holding byte not replaced");
   a_tx_full_drop: assert property (tx_wr && fifo_en && tx_full && !tx_pop && !en_chg
                                    |=> tx_full && tx_dout == $past(tx_dout))
      else $error("write to full transmit fifo not dropped");
   a_status_flags: assert property (rd_acc && pend_addr_q == ufds_pkg::FIFO_STATUS_ADDR
                                    |=> HRDATA[4:1] == $past({rx_full, !rx_empty, tx_empty, !tx_full}))
      else $error("fifo status flags wrong");
   a_status_reserved: assert property (rd_acc && pend_addr_q == ufds_pkg::FIFO_STATUS_ADDR
                                       |=> HRDATA[31:5] == '0 && !HRDATA[0])
      else $error("reserved status bits not zero");
   a_tx_start_bit: assert property (tx_pop && !ir_mode |-> ##2 !SER_OUT [*8])
      else $error("start bit not driven");
   a_bus_wait: assert property (take |=> !HREADYOUT ##1 HREADYOUT)
      else $error("bus answer not one wait state");

   c_rx_overrun: cover property (rx_got_q && fifo_en && rx_full);
   c_tx_full:    cover property (tx_wr && tx_full);
   c_alias_read: cover property (rx_pop && !rx_empty);
   c_irq:        cover property ($rose(IRQ));

endmodule : ufds_top

// ==== ufds_far.sv ====
/*
 Far-end UART model: 8N1 sender on the receive line, decoder on the transmit line.
 Assumes 16 clock cycles per bit and a free-running system clock.
*/
module ufds_far (
   // Clock
   input  wire logic       clk,
   // Serial lines
   input  wire logic       ser_out,
   output logic            ser_in,
   // Decoded traffic
   output logic [7:0]      last,
   output int              rxn
);
   initial begin
      ser_in = 1'b1;
      rxn    = 0;
      last   = 8'h00;
   end
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         ser_in <= f[i];
         repeat (16) @(posedge clk);
      end
   endtask : send
   // Mid-bit sampling, so a cycle of skew is harmless
   always begin
      @(negedge ser_out);
      repeat (8) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         repeat (16) @(posedge clk);
         if (i < 8) last[i] = ser_out;
      end
      rxn++;
   end
endmodule : ufds_far

// ==== testbench.sv ====
/*
 Self-checking bench for the UART data path slice.
 Assumes the AHB slave answers with one wait cycle and the far end runs 16 cycles per bit.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        SYS_CLK, RESET_N, HSEL, HWRITE, HREADYOUT, HRESP, SER_IN, SER_OUT, IR_OUT_N, IRQ;
   logic [31:0] HADDR, HWDATA, HRDATA, r;
   logic [1:0]  HTRANS;
   logic [7:0]  last;
   int          bad_count = 0, comparisons = 0, rxn;
   typedef struct {logic w; logic [31:0] a; logic [31:0] d;} ufds_row_type;
   ufds_row_type rows [8] = '{
      '{1'b0, ufds_pkg::FIFO_STATUS_ADDR, 32'h6}, '{1'b1, ufds_pkg::FIFO_STATUS_ADDR, 32'hFFFFFFFF},
      '{1'b0, ufds_pkg::FIFO_STATUS_ADDR, 32'h6}, '{1'b0, 32'h50001300, 32'h0},
      '{1'b1, 32'h50001300, 32'h5}, '{1'b0, 32'h50001300, 32'h0},
      '{1'b0, ufds_pkg::CTRL_ADDR, 32'h0}, '{1'b0, ufds_pkg::LINE_STATUS_ADDR, 32'h20}};
   // Infrared output looped back, so infrared mode receives its own characters
   ufds_top DUT (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SER_IN(SER_IN), .IR_IN(!IR_OUT_N), .SER_OUT(SER_OUT),
      .IR_OUT_N(IR_OUT_N), .IRQ(IRQ));
   ufds_far u_far (.clk(SYS_CLK), .ser_out(SER_OUT), .ser_in(SER_IN), .last(last), .rxn(rxn));
   task automatic results();
      if (bad_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic hwait();
      int n;
      n = 0;
      do begin
         @(posedge SYS_CLK);
         n++;
         if (n > 50) begin
            bad_count++;
            results();
         end
      end while (HREADYOUT !== 1'b1);
   endtask : hwait
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      HSEL   <= 1'b1;
      HTRANS <= 2'h2;
      HADDR  <= a;
      HWRITE <= w;
      hwait();
      HSEL   <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      hwait();
      q = HRDATA;
   endtask : xfer
   task automatic waitrx(input int n);
      for (int k = 0; rxn < n; k++) begin
         if (k > 5000) begin
            bad_count++;
            results();
         end
         @(posedge SYS_CLK);
      end
   endtask : waitrx
   initial begin
      SYS_CLK = 1'b0;
      forever #10 SYS_CLK = ~SYS_CLK;
   end
   initial begin
      {RESET_N, HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
      repeat (3) @(posedge SYS_CLK);
      RESET_N <= 1'b1;
      foreach (rows[i]) begin
         xfer(rows[i].w, rows[i].a, rows[i].d, r);
         if (!rows[i].w) chk(r, rows[i].d);
      end
      xfer(1'b1, ufds_pkg::CTRL_ADDR, 32'h1, r);
      // First byte leaves at once, so 16 more fill the FIFO and the last is dropped
      for (int i = 0; i < 18; i++) xfer(1'b1, ufds_pkg::ALIAS_FIRST_ADDR + 4 * (i % 16), i, r);
      xfer(1'b0, ufds_pkg::FIFO_STATUS_ADDR, 32'h0, r);
      chk(r, 32'h0);
      waitrx(17);
      repeat (300) @(posedge SYS_CLK);
      chk(32'(rxn), 32'd17);
      chk({24'h0, last}, 32'h10);
      for (int i = 0; i < 17; i++) u_far.send(8'(8'h40 + i));
      xfer(1'b0, ufds_pkg::FIFO_STATUS_ADDR, 32'h0, r);
      chk(r, 32'h1E);
      xfer(1'b0, ufds_pkg::LINE_STATUS_ADDR, 32'h0, r);
      chk(r, 32'h23);
      for (int i = 0; i < 16; i++) begin
         xfer(1'b0, ufds_pkg::ALIAS_FIRST_ADDR + 4 * i, 32'h0, r);
         chk(r, 32'h40 + i);
      end
      xfer(1'b0, ufds_pkg::FIFO_STATUS_ADDR, 32'h0, r);
      chk(r, 32'h6);
      chk(IRQ, 1'b0);
      xfer(1'b1, ufds_pkg::INT_STATUS_ADDR, 32'h7, r);
      xfer(1'b1, ufds_pkg::INT_MASK_ADDR, 32'h1, r);
      xfer(1'b1, ufds_pkg::CTRL_ADDR, 32'h0, r);
      u_far.send(8'h11);
      u_far.send(8'h22);
      repeat (3) @(posedge SYS_CLK);
      chk(IRQ, 1'b1);
      xfer(1'b0, ufds_pkg::RX_TX_DATA_ALIAS_15_ADDR, 32'h0, r);
      chk(r, 32'h22);
      xfer(1'b0, ufds_pkg::LINE_STATUS_ADDR, 32'h0, r);
      chk(r, 32'h22);
      xfer(1'b1, ufds_pkg::INT_STATUS_ADDR, 32'h1, r);
      repeat (2) @(posedge SYS_CLK);
      chk(IRQ, 1'b0);
      // Second write waits behind the busy transmitter and the third replaces it
      for (int i = 0; i < 3; i++) xfer(1'b1, ufds_pkg::ALIAS_FIRST_ADDR + 4 * i, 32'hA1 + 32'h11 * i, r);
      xfer(1'b0, ufds_pkg::LINE_STATUS_ADDR, 32'h0, r);
      chk(r, 32'h0);
      waitrx(19);
      repeat (300) @(posedge SYS_CLK);
      chk(32'(rxn), 32'h13);
      chk({24'h0, last}, 32'hC3);
      xfer(1'b1, ufds_pkg::CTRL_ADDR, 32'h2, r);
      xfer(1'b1, ufds_pkg::ALIAS_FIRST_ADDR, 32'h5A, r);
      repeat (200) @(posedge SYS_CLK);
      xfer(1'b0, ufds_pkg::LINE_STATUS_ADDR, 32'h0, r);
      chk(r, 32'h21);
      xfer(1'b0, ufds_pkg::ALIAS_FIRST_ADDR, 32'h0, r);
      chk(r, 32'h5A);
      chk(32'(rxn), 32'h13);
      chk({31'h0, HRESP}, 32'h0);
      // Reset in mid-run with a received byte still unread
      xfer(1'b1, ufds_pkg::ALIAS_FIRST_ADDR, 32'h3C, r);
      repeat (200) @(posedge SYS_CLK);
      xfer(1'b0, ufds_pkg::FIFO_STATUS_ADDR, 32'h0, r);
      chk(r, 32'hE);
      RESET_N <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
      RESET_N <= 1'b1;
      xfer(1'b0, ufds_pkg::FIFO_STATUS_ADDR, 32'h0, r);
      chk(r, 32'h6);
      results();
   end
endmodule : testbench
